// file: serial_peer.sv
// far-side receiving port model
module serial_peer (
  input logic i_ref_clk,
  input logic i_sclk,
  input logic i_data,
  input logic i_ready,
  output logic o_cts_n,
  output logic [7:0] o_byte,
  output int o_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_q = 1'b1;
  logic data_q = 1'b1;
  logic [7:0] shift_q = 8'h00;
  int bits = 0;
  int cnt = 0;
  // low lets the sender start; a slow peer holds it high
  assign o_cts_n = ~i_ready;
  assign o_count = cnt;
  // takes the bit held just before each rise, lsb first
  always @(posedge i_ref_clk) begin
    sclk_q <= i_sclk;
    data_q <= i_data;
    if (i_sclk && !sclk_q) begin
      shift_q <= {data_q, shift_q[7:1]};
      bits <= (bits == 7) ? 0 : bits + 1;
      if (bits == 7) begin
        o_byte <= {data_q, shift_q[7:1]};
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// file: sync_serial_transmitter.v
// clock synchronous serial channel: transmitter, receiver, handshake, Avalon-MM registers
// Contract
// - mode bits 0..2 choose parallel, clock synchronous or asynchronous pin use
// - synchronous mode is mode bit 0 set with bits 1 and 2 clear
// - every synchronous character is exactly eight data bits
// - mode bit 3 clear selects internal clock, set selects external clock
// - mode bits 4..6 ignored in synchronous mode; software keeps bit 7 zero
// - control zero bits 0,1 pick internal source; ignored with external clock
// - shift clock is source divided by rate value plus one, then two
// - control zero bit 2 selects clear-to-send input or request-to-send output
// - control zero bit 4 set disables handshake and frees the pin
// - start needs enable set, buffer-empty clear and clear-to-send low
// - data bits change on shift clock falling edges, least significant first
// - buffer write clears buffer-empty; move to shift register sets it
// - next byte loads automatically once shifter empties and start holds
// - with request-to-send selected, clear-to-send is ignored for start
// - once started, flags and clear-to-send are ignored until character ends
// - start is checked only in end window, allowing back to back bytes
// - shift-empty sets the cycle after window rises, clears at start
// - buffer-empty rising sets the transmit interrupt request bit
// - internal clock may drive one of three clock pins; no mid-character change
// - pin codes 00/01 main pin, 10 receive pin, 11 handshake pin
// - idle receive-data pin drives high if direction bit set, else floats; the code floats it always with pin code 00 or an external clock
// - receiver samples and shifts one bit per incoming clock rising edge
// - request-to-send goes low when ready, high again when reception starts
//
// Added by the designer: the address map and the Avalon-MM register port.
`include "sync_serial_tx_defs.vh"

module sync_serial_transmitter (
  input wire i_ref_clk,
  input wire i_sys_rst,
  input wire [5:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  input wire i_shift_clock_in,
  input wire i_serial_data_in,
  input wire i_clear_to_send_in,
  output reg o_serial_data_out,
  output reg o_serial_data_oe,
  output reg o_main_clock_pin,
  output reg o_main_clock_oe,
  output reg o_aux_clock_out_a,
  output reg o_aux_clock_out_a_oe,
  output reg o_aux_clock_out_b,
  output reg o_aux_clock_out_b_oe,
  output wire o_tx_irq_req
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_HIGH = 3'b010;
  localparam [2:0] ST_LOW = 3'b100;
  // reset words held as constants so that single flag bits can be picked out
  localparam [7:0] RST_C0 = `RST_CONTROL_ZERO;
  localparam [7:0] RST_C1 = `RST_CONTROL_ONE;

  reg [7:0] mode_q;
  reg [7:0] ctrl0_q;
  reg tx_en_q, ti_q, rx_en_q, ri_q, tx_empty_q;
  reg [7:0] rate_q;
  reg [7:0] txbuf_q;
  reg [7:0] rxbuf_q;
  reg [7:0] fsel_q;
  reg [7:0] pdir_q;
  reg irq_q;
  reg ack_q;
  reg [2:0] state_q;
  reg [7:0] shreg_q;
  reg [2:0] bitcnt_q;
  reg [5:0] pre_q;
  reg [7:0] brg_q;
  reg [7:0] rxsh_q;
  reg [2:0] rxcnt_q;
  reg rts_hold_q;
  reg rts_n_q;
  reg sclk_m_q, sclk_s_q, sclk_d_q;
  reg rxd_m_q, rxd_s_q;
  reg cts_m_q, cts_s_q;

  ////////////////////////////////////////////////////////////////////////
  // decoded configuration
  // mode decode
  // sync code
  // mode bits 4..7 are deliberately not looked at here
  // ignored bits
  wire sync_mode = (mode_q[2:0] == `MODE_SYNC_CODE);
  wire ext_clk = mode_q[`MODE_EXT_CLK_BIT];
  wire hs_off = ctrl0_q[`C0_HS_DISABLE_BIT];
  wire rts_sel = ctrl0_q[`C0_RTS_SEL_BIT];
  wire [1:0] pin_sel = fsel_q[1:0];
  wire multi_clk = sync_mode && !ext_clk && (pin_sel != 2'b00);
  wire idle = state_q[0];
  // the end window is simply "no character in flight"
  wire tend = idle;

  // bus handshake: one wait cycle, then the access completes
  wire req = i_avs_read | i_avs_write;
  wire acc = req & ack_q;
  wire [3:0] widx = i_avs_address[5:2];
  wire buf_wr = acc && i_avs_write && i_avs_byteenable[0] && (widx == `REG_TX_BUFFER);
  wire rxbuf_rd = acc && i_avs_read && (widx == `REG_RX_BUFFER);
  assign o_avs_waitrequest = req & ~ack_q;
  assign o_tx_irq_req = irq_q;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and external clock edges
  // two stages before any logic; the third stage only feeds edge detection
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_m_q <= 1'b1;
      sclk_s_q <= 1'b1;
      sclk_d_q <= 1'b1;
      rxd_m_q <= 1'b1;
      rxd_s_q <= 1'b1;
      cts_m_q <= 1'b1;
      cts_s_q <= 1'b1;
    end else begin
      sclk_m_q <= i_shift_clock_in;
      sclk_s_q <= sclk_m_q;
      sclk_d_q <= sclk_s_q;
      rxd_m_q <= i_serial_data_in;
      rxd_s_q <= rxd_m_q;
      cts_m_q <= i_clear_to_send_in;
      cts_s_q <= cts_m_q;
    end
  end

  wire ext_rise = sclk_s_q & ~sclk_d_q;
  wire ext_fall = ~sclk_s_q & sclk_d_q;

  ////////////////////////////////////////////////////////////////////////
  // internal source and bit-rate divider
  // source pick
  reg src_tick;
  always @* begin
    case (ctrl0_q[`C0_CLK_SRC_HI:`C0_CLK_SRC_LO])
      2'b00: src_tick = 1'b1;
      2'b01: src_tick = (pre_q[2:0] == `SRC_DIV8_M1);
      2'b10: src_tick = (pre_q[4:0] == `SRC_DIV32_M1);
      default: src_tick = (pre_q == `SRC_DIV64_M1);
    endcase
  end

  // divide by n+1; each half tick toggles the clock, giving the /2
  wire half_tick = src_tick && (brg_q == rate_q);
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pre_q <= 6'h00;
      brg_q <= 8'h00;
    end else begin
      pre_q <= pre_q + 6'h01;
      if (idle) begin
        brg_q <= 8'h00;
      end else if (src_tick) begin
        brg_q <= half_tick ? 8'h00 : brg_q + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit sequencer
  // start gate
  // cts bypass with rts selected or handshake off
  wire cts_ok = rts_sel | hs_off | ~cts_s_q;
  // start checked only in the end window
  wire start = sync_mode && tend && tx_en_q && !ti_q && cts_ok;
  wire fall_evt = state_q[1] && (ext_clk ? ext_fall : half_tick);
  wire rise_evt = state_q[2] && (ext_clk ? ext_rise : half_tick);

  // no start inputs are consulted outside ST_IDLE
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
      shreg_q <= 8'hff;
      bitcnt_q <= 3'd0;
      o_serial_data_out <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          o_serial_data_out <= 1'b1;
          if (start) begin
            shreg_q <= txbuf_q;
            bitcnt_q <= 3'd0;
            state_q <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (fall_evt) begin
            o_serial_data_out <= shreg_q[0];
            shreg_q <= {1'b1, shreg_q[7:1]};
            state_q <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (rise_evt) begin
            if (bitcnt_q == `CHAR_BITS_M1) begin
              state_q <= ST_IDLE;
            end else begin
              bitcnt_q <= bitcnt_q + 3'd1;
              state_q <= ST_HIGH;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // internal shift clock; idles high
  wire shift_clk = ~state_q[2];

  ////////////////////////////////////////////////////////////////////////
  // receive shifter and request-to-send
  // receiver follows its own generated clock in internal mode
  wire rx_rise = ext_clk ? ext_rise : rise_evt;
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rxsh_q <= 8'h00;
      rxcnt_q <= 3'd0;
      rxbuf_q <= 8'h00;
      rts_hold_q <= 1'b0;
      rts_n_q <= 1'b1;
    end else begin
      if (!rx_en_q || !sync_mode) begin
        rxcnt_q <= 3'd0;
        rts_hold_q <= 1'b0;
      end else if (rx_rise) begin
        // sample and shift one bit per rising edge
        rxsh_q <= {rxd_s_q, rxsh_q[7:1]};
        rxcnt_q <= rxcnt_q + 3'd1;
        rts_hold_q <= 1'b1;
        if (rxcnt_q == `CHAR_BITS_M1) begin
          rxbuf_q <= {rxd_s_q, rxsh_q[7:1]};
        end
      end else if (buf_wr) begin
        rts_hold_q <= 1'b0;
      end
      // low when enabled, buffer loaded and reception not yet begun
      rts_n_q <= ~(rx_en_q && !ti_q && !rts_hold_q && !rx_rise);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin routing
  // only the internal clock may fan out to the extra pins
  // code 00/01 main, 10 receive pin, 11 handshake pin
  // idle receive pin high or floating by direction bit, only with the internal clock on pin code 01 or 11
  always @* begin
    o_serial_data_oe = sync_mode;
    o_main_clock_pin = 1'b1;
    o_main_clock_oe = sync_mode && !ext_clk;
    o_aux_clock_out_a = 1'b1;
    o_aux_clock_out_a_oe = 1'b0;
    o_aux_clock_out_b = 1'b1;
    o_aux_clock_out_b_oe = 1'b0;
    if (multi_clk) begin
      case (pin_sel)
        2'b10: begin
          o_aux_clock_out_a = shift_clk;
          o_aux_clock_out_a_oe = 1'b1;
        end
        2'b11: begin
          o_aux_clock_out_a_oe = pdir_q[`PORT_DIR_RXD_BIT];
          o_aux_clock_out_b = shift_clk;
          o_aux_clock_out_b_oe = 1'b1;
        end
        default: begin
          o_main_clock_pin = shift_clk;
          o_aux_clock_out_a_oe = pdir_q[`PORT_DIR_RXD_BIT];
        end
      endcase
    end else begin
      o_main_clock_pin = ext_clk ? 1'b1 : shift_clk; // pin is an input with an external clock
      if (sync_mode && rts_sel && !hs_off) begin
        o_aux_clock_out_b = rts_n_q;
        o_aux_clock_out_b_oe = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers and bus slave
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ack_q <= 1'b0;
      o_avs_readdata <= 32'h00000000;
      mode_q <= `RST_MODE_SELECT;
      ctrl0_q <= `RST_CONTROL_ZERO;
      tx_en_q <= RST_C1[`C1_TX_EN_BIT];
      ti_q <= RST_C1[`C1_TI_BIT];
      rx_en_q <= RST_C1[`C1_RX_EN_BIT];
      ri_q <= RST_C1[`C1_RI_BIT];
      tx_empty_q <= RST_C0[`C0_TX_EMPTY_BIT];
      rate_q <= `RST_BIT_RATE;
      txbuf_q <= 8'h00;
      fsel_q <= `RST_FUNC_SELECT;
      pdir_q <= `RST_PORT_DIR;
      irq_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
      // read data captured in the wait cycle, stands while waitrequest is low
      if (req && !ack_q) begin
        case (widx)
          `REG_MODE_SELECT: o_avs_readdata <= {24'h000000, mode_q};
          `REG_CONTROL_ZERO: o_avs_readdata <= {24'h000000, ctrl0_q[7:4], tx_empty_q, ctrl0_q[2:0]};
          `REG_CONTROL_ONE: o_avs_readdata <= {28'h0000000, ri_q, rx_en_q, ti_q, tx_en_q};
          `REG_BIT_RATE: o_avs_readdata <= {24'h000000, rate_q};
          `REG_RX_BUFFER: o_avs_readdata <= {24'h000000, rxbuf_q};
          `REG_FUNC_SELECT: o_avs_readdata <= {24'h000000, fsel_q};
          `REG_PORT_DIR: o_avs_readdata <= {24'h000000, pdir_q};
          `REG_TX_IRQ_CTRL: o_avs_readdata <= {28'h0000000, irq_q, 3'b000};
          default: o_avs_readdata <= 32'h00000000;
        endcase
      end
      if (acc && i_avs_write && i_avs_byteenable[0]) begin
        case (widx)
          `REG_MODE_SELECT: mode_q <= i_avs_writedata[7:0];
          `REG_CONTROL_ZERO: ctrl0_q <= i_avs_writedata[7:0];
          `REG_CONTROL_ONE: begin
            tx_en_q <= i_avs_writedata[`C1_TX_EN_BIT];
            rx_en_q <= i_avs_writedata[`C1_RX_EN_BIT];
          end
          `REG_BIT_RATE: rate_q <= i_avs_writedata[7:0];
          `REG_TX_BUFFER: txbuf_q <= i_avs_writedata[7:0];
          `REG_FUNC_SELECT: fsel_q <= i_avs_writedata[7:0];
          `REG_PORT_DIR: pdir_q <= i_avs_writedata[7:0];
          default: ;
        endcase
      end
      // write clears, transfer sets; a write in the load cycle wins so new data is kept
      if (buf_wr) begin
        ti_q <= 1'b0;
      end else if (start) begin
        ti_q <= 1'b1;
      end
      // rising buffer-empty sets the request; set beats software clear
      if (start && !buf_wr) begin
        irq_q <= 1'b1;
      end else if (acc && i_avs_write && i_avs_byteenable[0] && (widx == `REG_TX_IRQ_CTRL)) begin
        irq_q <= i_avs_writedata[`IRQ_REQ_BIT];
      end
      // shift-empty one cycle after the window, cleared on start
      if (start) begin
        tx_empty_q <= 1'b0;
      end else if (tend) begin
        tx_empty_q <= 1'b1;
      end
      // receive-full flag: set on completed byte, cleared by read or disable
      if (rx_en_q && sync_mode && rx_rise && rxcnt_q == `CHAR_BITS_M1) begin
        ri_q <= 1'b1;
      end else if (rxbuf_rd || !rx_en_q) begin
        ri_q <= 1'b0;
      end
    end
  end

endmodule

// file: sync_serial_transmitter_checker.sv
// port-level concurrent checks for the synchronous transmitter
module sync_serial_transmitter_checker (
  input wire i_ref_clk,
  input wire i_sys_rst,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  input wire o_serial_data_out,
  input wire o_serial_data_oe,
  input wire o_main_clock_pin,
  input wire o_main_clock_oe,
  input wire o_aux_clock_out_a,
  input wire o_aux_clock_out_a_oe,
  input wire o_aux_clock_out_b,
  input wire o_aux_clock_out_b_oe,
  input wire o_tx_irq_req
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////
  // shift clock as seen on whichever pin carries it
  wire req = i_avs_read | i_avs_write;
  wire sck = o_main_clock_pin & (o_aux_clock_out_a | ~o_aux_clock_out_a_oe) & (o_aux_clock_out_b | ~o_aux_clock_out_b_oe);
  AST_ONE_WAIT: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus wait longer than one cycle");
  AST_WAIT_FIRST: assert property (req && !$past(req) |-> o_avs_waitrequest)
    else $error("request answered without a wait cycle");
  AST_RD_BYTE: assert property (i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  AST_SYNC_OE: assert property (o_main_clock_oe |-> o_serial_data_oe)
    else $error("clock driven outside synchronous mode");
  AST_IDLE_CLK: assert property (!o_main_clock_oe |-> o_main_clock_pin)
    else $error("undriven clock pin not high");
  AST_ONE_PIN: assert property (!o_main_clock_pin |-> o_aux_clock_out_a || !o_aux_clock_out_a_oe)
    else $error("clock on two pins at once");
  AST_DATA_HOLD: assert property (!sck && !$past(sck) |-> $stable(o_serial_data_out))
    else $error("data changed while shift clock low");
  AST_START_IDLE: assert property ($rose(o_tx_irq_req) && !$past(i_avs_write) |-> sck && o_serial_data_out)
    else $error("start while line not at rest");
  AST_START_CLK: assert property ($rose(o_tx_irq_req) && !$past(i_avs_write) && o_main_clock_oe |-> ##[1:600] !sck)
    else $error("no shift clock after start");
endmodule
bind sync_serial_transmitter sync_serial_transmitter_checker u_chk (.i_ref_clk, .i_sys_rst, .i_avs_read,
  .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .o_serial_data_out, .o_serial_data_oe, .o_main_clock_pin,
  .o_main_clock_oe, .o_aux_clock_out_a, .o_aux_clock_out_a_oe, .o_aux_clock_out_b, .o_aux_clock_out_b_oe,
  .o_tx_irq_req);

// file: sync_serial_tx_defs.vh
// constants for the clock synchronous serial transmitter
`ifndef SYNC_SERIAL_TX_DEFS_VH
`define SYNC_SERIAL_TX_DEFS_VH

// register word indices (byte address = index * 4)
`define REG_MODE_SELECT 4'h0
`define REG_CONTROL_ZERO 4'h1
`define REG_CONTROL_ONE 4'h2
`define REG_BIT_RATE 4'h3
`define REG_TX_BUFFER 4'h4
`define REG_RX_BUFFER 4'h5
`define REG_FUNC_SELECT 4'h6
`define REG_PORT_DIR 4'h7
`define REG_TX_IRQ_CTRL 4'h8

// reset values
`define RST_MODE_SELECT 8'h00
`define RST_CONTROL_ZERO 8'h08
`define RST_CONTROL_ONE 8'h02
`define RST_BIT_RATE 8'h00
`define RST_FUNC_SELECT 8'h00
`define RST_PORT_DIR 8'h00

// mode select fields
`define MODE_SYNC_CODE 3'b001
`define MODE_EXT_CLK_BIT 3
// control zero fields
`define C0_CLK_SRC_LO 0
`define C0_CLK_SRC_HI 1
`define C0_RTS_SEL_BIT 2
`define C0_TX_EMPTY_BIT 3
`define C0_HS_DISABLE_BIT 4
// control one fields
`define C1_TX_EN_BIT 0
`define C1_TI_BIT 1
`define C1_RX_EN_BIT 2
`define C1_RI_BIT 3
// port direction bit for the receive-data pin
`define PORT_DIR_RXD_BIT 2
// transmit interrupt control request bit
`define IRQ_REQ_BIT 3

// character length and internal source divisors (minus one)
`define CHAR_BITS_M1 3'd7
`define SRC_DIV8_M1 6'd7
`define SRC_DIV32_M1 6'd31
`define SRC_DIV64_M1 6'd63

`endif

// file: testbench.sv
// self-checking bench for the synchronous transmitter
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, rd, wr, xclk, rdy, dout, doe, mclk, moe, ax, axe, bx, bxe, irq, wt, cts, sp, sdi;
  logic [5:0] adr;
  logic [3:0] be;
  logic [31:0] wd, rq, rv;
  logic [7:0] pb, d, d2;
  logic [2:0] pin_p;
  int pc, n, i, bad_count = 0, n_tests = 0, en = 0, cyc = 0, lastf = 0, per = 0, fc[3];
  logic [5:0] ra[7] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h18, 6'h1c, 6'h24};
  logic [7:0] rz[7] = '{8'h00, 8'h08, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
  wire [2:0] pin = {bx, ax, mclk};
  wire sck = xclk & mclk & (ax | ~axe) & (bx | ~bxe);
  sync_serial_transmitter dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rq),
    .o_avs_waitrequest(wt), .i_shift_clock_in(xclk), .i_serial_data_in(sdi), .i_clear_to_send_in(cts),
    .o_serial_data_out(dout), .o_serial_data_oe(doe), .o_main_clock_pin(mclk), .o_main_clock_oe(moe),
    .o_aux_clock_out_a(ax), .o_aux_clock_out_a_oe(axe), .o_aux_clock_out_b(bx), .o_aux_clock_out_b_oe(bxe),
    .o_tx_irq_req(irq));
  serial_peer peer (.i_ref_clk(clk), .i_sclk(sck), .i_data(dout), .i_ready(rdy), .o_cts_n(cts),
    .o_byte(pb), .o_count(pc));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // shift clock period and falls per pin, measured in reference cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sp <= sck;
    pin_p <= pin;
    if (sp && !sck) begin
      per <= cyc - lastf;
      lastf <= cyc;
    end
    for (int k = 0; k < 3; k++) if (pin_p[k] && !pin[k]) fc[k] <= fc[k] + 1;
  end
  // expected half period: rate plus one times the source divisor
  function automatic int half(input int s, input int r);
    return (r + 1) * (s == 0 ? 1 : s == 1 ? 8 : s == 2 ? 32 : 64);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  // one bus access; holds the request until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] v);
    int t;
    t = 0;
    adr <= a;
    wd <= {24'h000000, v};
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      t++;
    end while (wt !== 1'b0 && t < 50);
    chk(wt, 32'h0);
    rv = rq;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // bounded wait for the peer to collect the next byte
  task automatic expect_byte(input logic [7:0] e);
    int t;
    t = 0;
    en++;
    while (pc < en && t < 9000) begin
      @(posedge clk);
      t++;
    end
    chk(pc, en);
    chk(pb, e);
  endtask
  task automatic report_and_stop;
    $display("bad_count %0d n_tests %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog: far beyond the slowest sequence
  initial begin
    repeat (80000) @(posedge clk);
    bad_count++;
    report_and_stop;
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(56158));
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 6'h00;
    wd = 32'h0;
    be = 4'hf;
    xclk = 1'b1;
    sdi = 1'b1;
    rdy = 1'b1;
    fc = '{0, 0, 0};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(doe, 32'h0);
    foreach (ra[k]) begin
      bus(1'b0, ra[k], 8'h00);
      chk(rv, rz[k]);
    end
    bus(1'b1, 6'h24, 8'hff);
    bus(1'b0, 6'h24, 8'h00);
    chk(rv, 32'h0);
    bus(1'b1, 6'h04, 8'h00);
    bus(1'b0, 6'h04, 8'h00);
    chk(rv, 32'h08);
    be <= 4'h0;
    bus(1'b1, 6'h0c, 8'h55);
    be <= 4'hf;
    bus(1'b0, 6'h0c, 8'h00);
    chk(rv, 32'h0);
    // bits 4..6 set must not disturb synchronous mode
    bus(1'b1, 6'h00, 8'h71);
    chk(doe, 32'h1);
    bus(1'b1, 6'h08, 8'h01);
    for (i = 0; i < 4; i++) begin
      n = $urandom_range(3);
      d = $urandom;
      bus(1'b1, 6'h04, 8'(i));
      bus(1'b1, 6'h0c, 8'(n));
      bus(1'b1, 6'h20, 8'h00);
      bus(1'b1, 6'h10, d);
      expect_byte(d);
      chk(per, 2 * half(i, n));
      bus(1'b0, 6'h20, 8'h00);
      chk(rv[3], 32'h1);
      chk(irq, 32'h1);
      bus(1'b0, 6'h08, 8'h00);
      chk(rv, 32'h03);
      bus(1'b0, 6'h04, 8'h00);
      chk(rv, 32'(i) | 32'h08);
    end
    // second byte written while the first is still shifting
    bus(1'b1, 6'h04, 8'h00);
    bus(1'b1, 6'h0c, 8'h00);
    d = $urandom;
    d2 = $urandom;
    bus(1'b1, 6'h10, d);
    bus(1'b1, 6'h10, d2);
    expect_byte(d);
    expect_byte(d2);
    // start gating: peer not ready, then rts select, then handshake off
    for (i = 0; i < 3; i++) begin
      bus(1'b1, 6'h04, i == 0 ? 8'h00 : i == 1 ? 8'h04 : 8'h10);
      chk(bxe, 32'(i == 1));
      bus(1'b1, 6'h08, 8'h00);
      rdy <= 1'b0;
      d = $urandom;
      bus(1'b1, 6'h10, d);
      repeat (30) @(posedge clk);
      chk(pc, en);
      bus(1'b1, 6'h08, 8'h01);
      if (i == 0) begin
        repeat (30) @(posedge clk);
        chk(pc, en);
        bus(1'b0, 6'h08, 8'h00);
        chk(rv, 32'h01);
        rdy <= 1'b1;
        @(negedge sck);
        rdy <= 1'b0;
      end
      expect_byte(d);
    end
    rdy <= 1'b1;
    // clock routed to each pin code in turn
    bus(1'b1, 6'h04, 8'h10);
    bus(1'b1, 6'h0c, 8'h01);
    for (i = 0; i < 4; i++) begin
      n = $urandom;
      bus(1'b1, 6'h1c, 8'(n));
      bus(1'b1, 6'h18, 8'(i));
      fc = '{0, 0, 0};
      d = $urandom;
      bus(1'b1, 6'h10, d);
      expect_byte(d);
      chk(fc[i == 3 ? 2 : i == 2 ? 1 : 0], 32'h8);
      if (i[0]) chk({axe, ax}, {n[2], 1'b1});
    end
    bus(1'b1, 6'h18, 8'h00);
    // external clock: source bits must be ignored
    bus(1'b1, 6'h00, 8'h09);
    bus(1'b1, 6'h04, 8'h13);
    d = $urandom;
    bus(1'b1, 6'h10, d);
    chk(moe, 32'h0);
    for (i = 0; i < 8; i++) begin
      xclk <= 1'b0;
      repeat (6) @(posedge clk);
      xclk <= 1'b1;
      repeat (6) @(posedge clk);
    end
    expect_byte(d);
    // receive side: external clock, request-to-send on the handshake pin, transmitter off
    bus(1'b1, 6'h08, 8'h04);
    bus(1'b1, 6'h04, 8'h04);
    bus(1'b1, 6'h10, 8'h00);
    repeat (4) @(posedge clk);
    chk({bxe, bx}, 32'h2);
    d = $urandom;
    for (i = 0; i < 8; i++) begin
      xclk <= 1'b0;
      sdi <= d[i];
      repeat (6) @(posedge clk);
      xclk <= 1'b1;
      repeat (6) @(posedge clk);
    end
    chk({bxe, bx}, 32'h3);
    bus(1'b0, 6'h08, 8'h00);
    chk(rv, 32'h0c);
    bus(1'b0, 6'h14, 8'h00);
    chk(rv, {24'h000000, d});
    bus(1'b0, 6'h08, 8'h00);
    chk(rv, 32'h04);
    report_and_stop;
  end
endmodule
